/* File: ftr_cfg.svh */
// fault trip recorder: codes, init values and timing constants
// assumes a single 20 MHz system clock
`ifndef FTR_CFG_SVH
`define FTR_CFG_SVH
`define FTR_CLK_HZ        32'h0131_2D00
`define FTR_STOP_TEST_S   32'h0000_0064
`define FTR_INIT_CLR_HIST 8'h00
`define FTR_E_NONE        8'h00
`define FTR_E_OC_CONST    8'h01
`define FTR_E_OC_DECEL    8'h02
`define FTR_E_OC_ACCEL    8'h03
`define FTR_E_OC_OTHER    8'h04
`define FTR_E_OVERLOAD    8'h05
`define FTR_E_BUS_OV      8'h07
`define FTR_E_NVMEM       8'h08
`define FTR_E_BUS_UV      8'h09
`define FTR_E_CPU         8'h11
`define FTR_E_EXT         8'h12
`define FTR_E_START_GRD   8'h13
`define FTR_E_GND         8'h14
`define FTR_E_IN_OV       8'h15
`define FTR_E_THERM       8'h21
`define FTR_E_DRIVER      8'h30
`define FTR_E_SAFE_STOP   8'h37
`define FTR_E_COMM_WDT    8'h60
`define FTR_PH_CONST      2'h0
`define FTR_PH_DECEL      2'h1
`define FTR_PH_ACCEL      2'h2
`endif

/* File: ftr_pkg.sv */
// fault trip recorder: shared types
// assumes nothing beyond the tool's package support
package ftr_pkg;
  typedef enum logic [2:0] {
    ST_PWRUP, ST_STOP, ST_RUN, ST_TRIP, ST_BROWN
  } ftr_state_e;
  typedef logic [7:0]  ftr_code_t;
  typedef logic [15:0] ftr_data_t;
  typedef struct packed {
    ftr_state_e st;
    ftr_code_t  code;
    logic       push;
    ftr_data_t  snap;
    logic       nv_mark;
  } ftr_main_s;
  typedef struct packed {
    ftr_code_t [2:0] code;
    ftr_data_t [2:0] data;
  } ftr_hist_s;
  typedef struct packed {
    logic [31:0] cnt;
    logic        done;
  } ftr_tmr_s;
endpackage

/* File: ftr_hist_if.sv */
// fault trip recorder: link between control and history store
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface ftr_hist_if;
  logic                        push;
  logic                        clr;
  ftr_pkg::ftr_code_t          code;
  ftr_pkg::ftr_data_t          data;
  ftr_pkg::ftr_code_t [2:0]    rec_code;
  ftr_pkg::ftr_data_t [2:0]    rec_data;
  modport ctrl  (output push, clr, code, data, input rec_code, rec_data);
  modport store (input push, clr, code, data, output rec_code, rec_data);
endinterface
`default_nettype wire

/* File: ftr_hist.sv */
// fault trip recorder: three-deep shifting fault history
// assumes push and clr are one-cycle pulses from the control
`timescale 1ns/1ps
`default_nettype none
module ftr_hist (
  input wire logic    clk,
  input wire logic    rst_b,
  ftr_hist_if.store   hif
);
  ftr_pkg::ftr_hist_s s_r;
  ftr_pkg::ftr_hist_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (hif.clr) begin
      s_nxt = '0;
    end
    // push after clear so a fault in the clearing cycle survives
    if (hif.push) begin
      s_nxt.code[2] = hif.clr ? '0 : s_r.code[1];
      s_nxt.code[1] = hif.clr ? '0 : s_r.code[0];
      s_nxt.data[2] = hif.clr ? '0 : s_r.data[1];
      s_nxt.data[1] = hif.clr ? '0 : s_r.data[0];
      s_nxt.code[0] = hif.code;
      s_nxt.data[0] = hif.data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hif.rec_code = s_r.code;
  assign hif.rec_data = s_r.data;

  property p_shift;
    @(posedge clk) disable iff (!rst_b)
    hif.push && !hif.clr |=> s_r.code[1] == $past(s_r.code[0])
      && s_r.code[2] == $past(s_r.code[1]) && s_r.code[0] == $past(hif.code);
  endproperty
  a_shift: assert property (p_shift) else $error("history shift wrong");

  property p_clr;
    @(posedge clk) disable iff (!rst_b)
    hif.clr && !hif.push |=> s_r == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("history not cleared");
endmodule
`default_nettype wire

/* File: ftr_top.sv */
// fault trip recorder: fault supervision, trip control, history
// assumes all inputs synchronous to CLK_SYS; pulses last one cycle
// Summary of operation
// - any fault records history, turns power output off, enters trip.
// - faults are watched while stopped as well as while running.
// - stop/reset key leaves the tripped state.
// - writing 00 to init select clears only the fault history.
// - over-current coded by phase: constant, decel, accel, other.
// - thermal overload trips with code 05.
// - DC bus over-voltage trips with code 07.
// - parameter memory fault trips with code 08.
// - DC bus under-voltage trips with code 09.
// - processor malfunction trips with code 11.
// - input set as external trip trips with code 12.
// - start guard with run at power-up trips 13, no run meanwhile.
// - power-up ground fault check trips with code 14.
// - after 100 s stopped, input over-voltage gives code 15.
// - power module over-temperature trips with code 21.
// - driver protection circuit error trips with code 30.
// - safety stop signal trips with code 37.
// - network watchdog expiry trips with code 60.
// - brownout shuts output, retries; failed restart logs under-voltage.
// - power lost with reset terminal on gives memory error next power-up.
// - operating data snapshot is stored with each fault entry.
// - three entries; each new fault shifts newest to middle to oldest.
`timescale 1ns/1ps
`default_nettype none
`include "ftr_cfg.svh"
module ftr_top #(
  parameter longint unsigned STOP_CYC =
    64'(`FTR_STOP_TEST_S) * 64'(`FTR_CLK_HZ)
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  input  wire logic        RUN_CMD,
  input  wire logic        STOP_RESET_KEY,
  input  wire logic        OC_DET,
  input  wire logic [1:0]  OP_PHASE,
  input  wire logic        OVERLOAD_DET,
  input  wire logic        BUS_OV_DET,
  input  wire logic        BUS_UV_DET,
  input  wire logic        NVMEM_ERR,
  input  wire logic        CPU_ERR,
  input  wire logic        EXTERNAL_TRIP_INPUT,
  input  wire logic        EXT_TRIP_CFG,
  input  wire logic        UNATTENDED_START_GUARD,
  input  wire logic        GND_FAULT_DET,
  input  wire logic        IN_OV_DET,
  input  wire logic        THERM_DET,
  input  wire logic        DRIVER_ERR,
  input  wire logic        SAFETY_STOP,
  input  wire logic        COMM_WDT_EXP,
  input  wire logic        BROWNOUT,
  input  wire logic        RESTART_FAIL,
  input  wire logic        RESET_INPUT_TERMINAL,
  input  wire logic        NV_RST_MARK_IN,
  input  wire logic        INIT_SELECT_WR,
  input  wire logic [7:0]  INIT_SELECT_PARAM,
  input  wire logic [15:0] OP_DATA,
  output logic             PWR_OUT_EN,
  output logic             TRIPPED,
  output logic [7:0]       ERR_CODE,
  output logic             NV_RST_MARK_OUT,
  output logic [7:0]       LATEST_FAULT_RECORD,
  output logic [7:0]       PRIOR_FAULT_RECORD,
  output logic [7:0]       OLDEST_FAULT_RECORD,
  output logic [15:0]      LATEST_FAULT_DATA,
  output logic [15:0]      PRIOR_FAULT_DATA,
  output logic [15:0]      OLDEST_FAULT_DATA
);
  ftr_pkg::ftr_main_s s_r;
  ftr_pkg::ftr_main_s s_nxt;
  ftr_pkg::ftr_code_t gen_f;
  logic               tmr_done;
  logic               stopped;

  ftr_hist_if hif ();

  ftr_hist ftr_hist_inst (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .hif   (hif)
  );

  assign stopped = (s_r.st == ftr_pkg::ST_STOP);

  ftr_timer #(
    .CYC (STOP_CYC)
  ) ftr_timer_inst (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .run   (stopped),
    .done  (tmr_done)
  );

  // general fault priority encoder, zero means no fault
  always_comb begin
    gen_f = `FTR_E_NONE;
    if (CPU_ERR) begin
      gen_f = `FTR_E_CPU;
    end else if (NVMEM_ERR) begin
      gen_f = `FTR_E_NVMEM;
    end else if (DRIVER_ERR) begin
      gen_f = `FTR_E_DRIVER;
    end else if (SAFETY_STOP) begin
      gen_f = `FTR_E_SAFE_STOP;
    end else if (THERM_DET) begin
      gen_f = `FTR_E_THERM;
    end else if (BUS_OV_DET) begin
      gen_f = `FTR_E_BUS_OV;
    end else if (BUS_UV_DET) begin
      gen_f = `FTR_E_BUS_UV;
    end else if (OC_DET) begin
      case (OP_PHASE)
        `FTR_PH_CONST: gen_f = `FTR_E_OC_CONST;
        `FTR_PH_DECEL: gen_f = `FTR_E_OC_DECEL;
        `FTR_PH_ACCEL: gen_f = `FTR_E_OC_ACCEL;
        default:       gen_f = `FTR_E_OC_OTHER;
      endcase
    end else if (OVERLOAD_DET) begin
      gen_f = `FTR_E_OVERLOAD;
    end else if (EXTERNAL_TRIP_INPUT && EXT_TRIP_CFG) begin
      gen_f = `FTR_E_EXT;
    end else if (COMM_WDT_EXP) begin
      gen_f = `FTR_E_COMM_WDT;
    end
  end

  always_comb begin
    ftr_pkg::ftr_code_t f;
    f = `FTR_E_NONE;
    s_nxt = s_r;
    s_nxt.push = 1'b0;
    s_nxt.nv_mark = RESET_INPUT_TERMINAL;
    case (s_r.st)
      ftr_pkg::ST_PWRUP: begin
        if (NV_RST_MARK_IN) begin
          f = `FTR_E_NVMEM;
        end else if (GND_FAULT_DET) begin
          f = `FTR_E_GND;
        end else if (UNATTENDED_START_GUARD && RUN_CMD) begin
          f = `FTR_E_START_GRD;
        end else begin
          f = gen_f;
        end
        if (f == `FTR_E_NONE) begin
          s_nxt.st = ftr_pkg::ST_STOP;
        end
      end
      ftr_pkg::ST_STOP: begin
        f = gen_f;
        if (f == `FTR_E_NONE && tmr_done && IN_OV_DET) begin
          f = `FTR_E_IN_OV;
        end
        if (f == `FTR_E_NONE) begin
          if (BROWNOUT) begin
            s_nxt.st = ftr_pkg::ST_BROWN;
          end else if (RUN_CMD) begin
            s_nxt.st = ftr_pkg::ST_RUN;
          end
        end
      end
      ftr_pkg::ST_RUN: begin
        f = gen_f;
        if (f == `FTR_E_NONE) begin
          if (BROWNOUT) begin
            s_nxt.st = ftr_pkg::ST_BROWN;
          end else if (!RUN_CMD) begin
            s_nxt.st = ftr_pkg::ST_STOP;
          end
        end
      end
      ftr_pkg::ST_BROWN: begin
        f = gen_f;
        if (f == `FTR_E_NONE) begin
          if (RESTART_FAIL) begin
            f = `FTR_E_BUS_UV;
          end else if (!BROWNOUT) begin
            s_nxt.st = ftr_pkg::ST_STOP;
          end
        end
      end
      ftr_pkg::ST_TRIP: begin
        // a general fault (gen_f nonzero) present with the key keeps the trip
        if (STOP_RESET_KEY && gen_f == `FTR_E_NONE) begin
          s_nxt.st = ftr_pkg::ST_STOP;
        end
      end
      default: begin
        s_nxt.st = ftr_pkg::ST_PWRUP;
      end
    endcase
    if (f != `FTR_E_NONE) begin
      s_nxt.st = ftr_pkg::ST_TRIP;
      s_nxt.code = f;
      s_nxt.push = 1'b1;
      s_nxt.snap = OP_DATA;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      s_r <= '{st: ftr_pkg::ST_PWRUP, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hif.push = s_r.push;
  assign hif.code = s_r.code;
  assign hif.data = s_r.snap;
  assign hif.clr  = INIT_SELECT_WR
    && INIT_SELECT_PARAM == `FTR_INIT_CLR_HIST;

  assign PWR_OUT_EN = (s_r.st == ftr_pkg::ST_RUN);
  assign TRIPPED    = (s_r.st == ftr_pkg::ST_TRIP);
  assign ERR_CODE   = s_r.code;
  assign NV_RST_MARK_OUT     = s_r.nv_mark;
  assign LATEST_FAULT_RECORD = hif.rec_code[0];
  assign PRIOR_FAULT_RECORD  = hif.rec_code[1];
  assign OLDEST_FAULT_RECORD = hif.rec_code[2];
  assign LATEST_FAULT_DATA   = hif.rec_data[0];
  assign PRIOR_FAULT_DATA    = hif.rec_data[1];
  assign OLDEST_FAULT_DATA   = hif.rec_data[2];

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  property p_trip_run;
    s_r.st == ftr_pkg::ST_RUN && gen_f != `FTR_E_NONE
      |=> TRIPPED && !PWR_OUT_EN && ERR_CODE == $past(gen_f) ##1 hif.rec_code[0] == ERR_CODE;
  endproperty
  a_trip_run: assert property (p_trip_run) else $error("run fault no trip");

  property p_trip_stop;
    stopped && CPU_ERR |=> TRIPPED && ERR_CODE == `FTR_E_CPU;
  endproperty
  a_trip_stop: assert property (p_trip_stop) else $error("stop fault missed");

  property p_clear;
    TRIPPED && STOP_RESET_KEY && gen_f == `FTR_E_NONE |=> stopped;
  endproperty
  a_clear: assert property (p_clear) else $error("trip not cleared");

  property p_oc_phase;
    s_r.st == ftr_pkg::ST_RUN && OC_DET && OP_PHASE == `FTR_PH_DECEL
      && !CPU_ERR && !NVMEM_ERR && !DRIVER_ERR && !SAFETY_STOP
      && !THERM_DET && !BUS_OV_DET && !BUS_UV_DET
      |=> ERR_CODE == `FTR_E_OC_DECEL;
  endproperty
  a_oc_phase: assert property (p_oc_phase) else $error("phase code wrong");

  property p_guard;
    s_r.st == ftr_pkg::ST_PWRUP && !NV_RST_MARK_IN && !GND_FAULT_DET
      && UNATTENDED_START_GUARD && RUN_CMD
      |=> TRIPPED && ERR_CODE == `FTR_E_START_GRD ##1 !PWR_OUT_EN;
  endproperty
  a_guard: assert property (p_guard) else $error("start guard failed");

  property p_gnd;
    s_r.st == ftr_pkg::ST_PWRUP && !NV_RST_MARK_IN && GND_FAULT_DET
      |=> ERR_CODE == `FTR_E_GND;
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground fault missed");

  property p_in_ov;
    stopped && tmr_done && IN_OV_DET && gen_f == `FTR_E_NONE
      |=> TRIPPED && ERR_CODE == `FTR_E_IN_OV;
  endproperty
  a_in_ov: assert property (p_in_ov) else $error("input ov missed");

  property p_brown;
    s_r.st == ftr_pkg::ST_BROWN && RESTART_FAIL && gen_f == `FTR_E_NONE
      && !PWR_OUT_EN |=> ERR_CODE == `FTR_E_BUS_UV;
  endproperty
  a_brown: assert property (p_brown) else $error("brownout wrong");

  property p_nv;
    s_r.st == ftr_pkg::ST_PWRUP && NV_RST_MARK_IN
      |=> ERR_CODE == `FTR_E_NVMEM;
  endproperty
  a_nv: assert property (p_nv) else $error("reset mark missed");

  property p_snap;
    s_r.st != ftr_pkg::ST_TRIP && s_nxt.st == ftr_pkg::ST_TRIP
      |-> ##2 LATEST_FAULT_DATA == $past(OP_DATA, 2);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot wrong");

  // a fault held during the trip must not add an entry
  property p_trip_hold;
    TRIPPED && gen_f != `FTR_E_NONE |=> TRIPPED && !hif.push;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip not held");

  property p_ext_off;
    !EXT_TRIP_CFG && EXTERNAL_TRIP_INPUT |-> gen_f != `FTR_E_EXT;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("ext trip unset");

  c_trip:  cover property (s_r.st == ftr_pkg::ST_RUN ##1 TRIPPED);
  c_clear: cover property (TRIPPED ##1 stopped);
  c_brown: cover property (s_r.st == ftr_pkg::ST_BROWN ##1 stopped);
  c_guard: cover property (TRIPPED && ERR_CODE == `FTR_E_START_GRD);
endmodule
`default_nettype wire

/* File: ftr_timer.sv */
// fault trip recorder: stopped-time counter
// assumes run stays high while the drive is stopped
`timescale 1ns/1ps
`default_nettype none
module ftr_timer #(
  parameter longint unsigned CYC = 64'h0000_0000_7735_9400
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      done
);
  ftr_pkg::ftr_tmr_s s_r;
  ftr_pkg::ftr_tmr_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!run) begin
      s_nxt = '0;
    end else if (!s_r.done) begin
      if (s_r.cnt == 32'(CYC - 64'h0000_0000_0000_0001)) begin
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;
endmodule
`default_nettype wire

/* File: ftr_plant.sv */
// keypad model: presses the stop/reset key for one clock on request
// assumes requests change shortly after the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module ftr_plant (
  input  wire logic clk,
  input  wire logic req,
  output logic      key
);
  initial key = 1'h0;
  // key level launched just after the edge, held one cycle
  always @(posedge clk) key <= #1 req;
endmodule
`default_nettype wire

/* File: ftr_top_test.sv */
// fault trip recorder testbench: trips, history, clear, power-up
// assumes ftr_top with a short stop timer and the keypad model
`timescale 1ns/1ps
`default_nettype none
`include "ftr_cfg.svh"
module ftr_top_test;
  logic        clk_sys, rst_b, run_cmd, kreq, key, oc_det, ext_cfg;
  logic        guard, gnd, in_ov, brown, rfail, rst_term, nv_in;
  logic        init_wr, pwr, trp, nv_out;
  logic [1:0]  phase;
  logic [9:0]  flt;
  logic [7:0]  init_val, err, r0, r1, r2;
  logic [15:0] op_data, d0, d1, d2;
  logic [7:0]  h [3];
  logic [15:0] hd [3];
  int          bad_count, cmp_count;
  localparam logic [7:0] CODES [10] = '{`FTR_E_OVERLOAD,
    `FTR_E_BUS_OV, `FTR_E_BUS_UV, `FTR_E_NVMEM,
    `FTR_E_CPU, `FTR_E_EXT, `FTR_E_THERM,
    `FTR_E_DRIVER, `FTR_E_SAFE_STOP, `FTR_E_COMM_WDT};
  localparam logic [7:0] OC_CODES [4] = '{`FTR_E_OC_CONST,
    `FTR_E_OC_DECEL, `FTR_E_OC_ACCEL, `FTR_E_OC_OTHER};

  ftr_top #(.STOP_CYC(20)) ftr_top_inst (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .RUN_CMD(run_cmd),
    .STOP_RESET_KEY(key), .OC_DET(oc_det), .OP_PHASE(phase),
    .OVERLOAD_DET(flt[0]), .BUS_OV_DET(flt[1]), .BUS_UV_DET(flt[2]),
    .NVMEM_ERR(flt[3]), .CPU_ERR(flt[4]), .EXTERNAL_TRIP_INPUT(flt[5]),
    .EXT_TRIP_CFG(ext_cfg), .UNATTENDED_START_GUARD(guard),
    .GND_FAULT_DET(gnd), .IN_OV_DET(in_ov), .THERM_DET(flt[6]),
    .DRIVER_ERR(flt[7]), .SAFETY_STOP(flt[8]), .COMM_WDT_EXP(flt[9]),
    .BROWNOUT(brown), .RESTART_FAIL(rfail),
    .RESET_INPUT_TERMINAL(rst_term), .NV_RST_MARK_IN(nv_in),
    .INIT_SELECT_WR(init_wr), .INIT_SELECT_PARAM(init_val),
    .OP_DATA(op_data), .PWR_OUT_EN(pwr), .TRIPPED(trp), .ERR_CODE(err),
    .NV_RST_MARK_OUT(nv_out), .LATEST_FAULT_RECORD(r0),
    .PRIOR_FAULT_RECORD(r1), .OLDEST_FAULT_RECORD(r2),
    .LATEST_FAULT_DATA(d0), .PRIOR_FAULT_DATA(d1), .OLDEST_FAULT_DATA(d2)
  );
  ftr_plant ftr_plant_inst (.clk(clk_sys), .req(kreq), .key(key));

  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_hist();
    chk("latest", r0, h[0]);
    chk("prior", r1, h[1]);
    chk("oldest", r2, h[2]);
    chk("latest data", d0, hd[0]);
    chk("prior data", d1, hd[1]);
    chk("oldest data", d2, hd[2]);
  endtask

  // fault already applied by caller in this cycle
  task automatic expect_trip(input logic [7:0] c);
    op_data = {c, ~c};
    cyc(1);
    chk("tripped", trp, 1'h1);
    chk("power off", pwr, 1'h0);
    chk("code", err, c);
    h[2] = h[1];
    h[1] = h[0];
    h[0] = c;
    hd[2] = hd[1];
    hd[1] = hd[0];
    hd[0] = {c, ~c};
    cyc(1);
    chk_hist();
    flt = '0;
    {oc_det, gnd, in_ov, brown, rfail} = '0;
  endtask

  task automatic press_key(input logic exp_trp);
    kreq = 1'h1;
    cyc(1);
    kreq = 1'h0;
    cyc(1);
    chk("trip after key", trp, exp_trp);
  endtask

  task automatic go_run();
    run_cmd = 1'h1;
    cyc(2);
    chk("running", pwr, 1'h1);
  endtask

  task automatic t_codes();
    for (int i = 0; i < 10; i++) begin
      go_run();
      flt[i] = 1'h1;
      expect_trip(CODES[i]);
      press_key(1'h0);
    end
    for (int j = 0; j < 4; j++) begin
      go_run();
      phase = 2'(j);
      oc_det = 1'h1;
      expect_trip(OC_CODES[j]);
      press_key(1'h0);
    end
  endtask

  task automatic t_stop_fault();
    run_cmd = 1'h0;
    cyc(2);
    chk("stopped", pwr, 1'h0);
    ext_cfg = 1'h0;
    flt[5] = 1'h1;
    cyc(1);
    chk("ext unset", trp, 1'h0);
    flt = 10'h010;
    ext_cfg = 1'h1;
    expect_trip(`FTR_E_CPU);
    flt[4] = 1'h1;
    press_key(1'h1);
    cyc(2);
    chk_hist();
    flt = '0;
    press_key(1'h0);
  endtask

  task automatic t_timer();
    in_ov = 1'h1;
    op_data = {`FTR_E_IN_OV, ~`FTR_E_IN_OV};
    // stop entered one edge ago; timer done after 20 stopped cycles
    cyc(20);
    chk("early input ov", trp, 1'h0);
    cyc(1);
    chk("input ov trip", trp, 1'h1);
    chk("input ov code", err, `FTR_E_IN_OV);
    h[2] = h[1];
    h[1] = h[0];
    h[0] = `FTR_E_IN_OV;
    hd[2] = hd[1];
    hd[1] = hd[0];
    hd[0] = op_data;
    cyc(1);
    chk_hist();
    in_ov = 1'h0;
    press_key(1'h0);
  endtask

  task automatic t_init();
    init_val = 8'h01;
    init_wr = 1'h1;
    cyc(1);
    init_wr = 1'h0;
    cyc(1);
    chk_hist();
    init_val = `FTR_INIT_CLR_HIST;
    init_wr = 1'h1;
    cyc(1);
    init_wr = 1'h0;
    cyc(1);
    h = '{default: 8'h00};
    hd = '{default: 16'h0000};
    chk_hist();
    chk("code kept", err, `FTR_E_IN_OV);
    rst_term = 1'h1;
    cyc(2);
    chk("marker set", nv_out, 1'h1);
    rst_term = 1'h0;
    cyc(2);
    chk("marker clear", nv_out, 1'h0);
  endtask

  task automatic t_brown();
    go_run();
    brown = 1'h1;
    cyc(1);
    chk("brown off", pwr, 1'h0);
    chk("brown no trip", trp, 1'h0);
    brown = 1'h0;
    cyc(2);
    chk("brown recover", trp, 1'h0);
    chk_hist();
    brown = 1'h1;
    cyc(1);
    rfail = 1'h1;
    expect_trip(`FTR_E_BUS_UV);
    run_cmd = 1'h0;
    press_key(1'h0);
  endtask

  task automatic powerup(input logic nv, g, gr, input logic [7:0] c);
    rst_b = 1'h0;
    {nv_in, gnd, guard, run_cmd} = {nv, g, gr, gr};
    cyc(8);
    rst_b = 1'h1;
    h = '{default: 8'h00};
    hd = '{default: 16'h0000};
    expect_trip(c);
    cyc(2);
    chk("no run while tripped", pwr, 1'h0);
    {nv_in, guard, run_cmd} = '0;
    press_key(1'h0);
  endtask

  initial begin
    {rst_b, run_cmd, kreq, oc_det, guard, gnd, in_ov, brown} = '0;
    {rfail, rst_term, nv_in, init_wr, phase, flt} = '0;
    ext_cfg = 1'h1;
    init_val = 8'h00;
    op_data = 16'h0000;
    h = '{default: 8'h00};
    hd = '{default: 16'h0000};
    cyc(8);
    rst_b = 1'h1;
    cyc(1);
    chk("idle trip", trp, 1'h0);
    t_codes();
    t_stop_fault();
    t_timer();
    t_init();
    t_brown();
    powerup(1'h1, 1'h0, 1'h0, `FTR_E_NVMEM);
    powerup(1'h0, 1'h1, 1'h0, `FTR_E_GND);
    powerup(1'h0, 1'h0, 1'h1, `FTR_E_START_GRD);
    give_verdict();
  end

  initial begin
    #(50 * 5000);
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
